// ==== core/tie_pkg.sv ====
// Package: opcodes, widths and reset values for the tail execute block
package tie_pkg;
    localparam int DATA_W = 8;
    localparam int REG_ADDR_W = 7;
    localparam int PAGE_W = 3;
    localparam int ROM_ADDR_W = PAGE_W + DATA_W;
    localparam int ROM_DATA_W = 14;
    localparam int HIGH_W = 6;
    localparam int HIGH_LSB = 8;
    localparam int NIB_W = 4;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [DATA_W-1:0] TMODE_RST = 8'h00;
    localparam logic [HIGH_W-1:0] HIGH_RST = 6'h00;
    localparam logic TO_RST = 1'b1;
    localparam logic PDN_RST = 1'b1;
    localparam logic TO_HALT = 1'b1;
    localparam logic PDN_HALT = 1'b0;
    localparam logic DEST_WORK = 1'b0;

    typedef enum logic [3:0] {
        TIE_OP_NONE = 4'h0,
        TIE_OP_HALT = 4'h1,
        TIE_OP_IMM_MINUS_WORK = 4'h2,
        TIE_OP_NIBBLE_EXCHANGE = 4'h3,
        TIE_OP_TIMER_MODE_LOAD = 4'h4,
        TIE_OP_TIMER_MODE_READ = 4'h5,
        TIE_OP_PROGRAM_WORD_READ = 4'h6,
        TIE_OP_REG_EXCLUSIVE_OR = 4'h7,
        TIE_OP_IMM_EXCLUSIVE_OR = 4'h8
    } tie_op_t;

    typedef enum logic [1:0] {
        TIE_ST_IDLE = 2'b00,
        TIE_ST_FETCH = 2'b01,
        TIE_ST_HALTED = 2'b10
    } tie_state_t;
endpackage

// ==== core/tie_flag_alu.sv ====
// Arithmetic unit: immediate minus work register, swap and exclusive-OR
module tie_flag_alu
    import tie_pkg::*;
(
    input wire tie_pkg::tie_op_t op_i,
    input wire logic [tie_pkg::DATA_W-1:0] work_i,
    input wire logic [tie_pkg::DATA_W-1:0] operand_i,
    output logic [tie_pkg::DATA_W-1:0] result_o,
    output logic zero_o,
    output logic nibble_borrow_o,
    output logic carry_o
);
    logic [DATA_W:0] diff;
    logic [NIB_W:0] low_diff;

    // ===========================================
    // Subtract with borrow-out and nibble borrow
    assign diff = {1'b0, operand_i} - {1'b0, work_i};
    assign low_diff = {1'b0, operand_i[NIB_W-1:0]}
        - {1'b0, work_i[NIB_W-1:0]};

    always_comb
    begin
        unique case (op_i)
            TIE_OP_IMM_MINUS_WORK: result_o = diff[DATA_W-1:0];
            TIE_OP_NIBBLE_EXCHANGE: result_o = {operand_i[NIB_W-1:0],
                operand_i[DATA_W-1:NIB_W]};
            TIE_OP_REG_EXCLUSIVE_OR,
            TIE_OP_IMM_EXCLUSIVE_OR:
                result_o = work_i ^ operand_i;
            default: result_o = operand_i;
        endcase
    end

    assign zero_o = (result_o == ZERO_BYTE);
    assign carry_o = ~diff[DATA_W];
    assign nibble_borrow_o = ~low_diff[NIB_W];
endmodule

// ==== core/tie_execute.sv ====
// Execute stage for halt, subtract, swap, timer mode, table read and XOR
// How it works
// - Halt pulses the watchdog clear output for one cycle and enters the halted state.
// - Immediate minus work goes to work; zero, nibble, carry flags.
// - Nibble exchange swaps the register's halves, flags untouched.
// - Destination 0 writes the work register, 1 writes the register.
// - Timer mode load copies work into the mode register in one cycle.
// - Timer mode read copies the mode register into work in one cycle.
// - Table read fetches at {page bits 2..0, work}, low byte to work.
// - Table read: bits 13..8 to the high latch, two cycles, no flags.
// - Register XOR routes by destination, sets only zero, one cycle.
// - Immediate XOR writes work, sets only zero, in one cycle.
module tie_execute
    import tie_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic op_valid_i,
    input wire tie_pkg::tie_op_t op_i,
    input wire logic [tie_pkg::DATA_W-1:0] imm_i,
    input wire logic [tie_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic dest_i,
    input wire logic [tie_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic [tie_pkg::PAGE_W-1:0] table_page_pointer_i,
    input wire logic [tie_pkg::ROM_DATA_W-1:0] rom_data_i,
    input wire logic wake_i,
    output logic busy_o,
    output logic [tie_pkg::REG_ADDR_W-1:0] reg_addr_o,
    output logic reg_we_o,
    output logic [tie_pkg::DATA_W-1:0] reg_wdata_o,
    output logic [tie_pkg::ROM_ADDR_W-1:0] rom_addr_o,
    output logic [tie_pkg::DATA_W-1:0] work_register_o,
    output logic [tie_pkg::DATA_W-1:0] timer_mode_reg_o,
    output logic [tie_pkg::HIGH_W-1:0] table_high_latch_o,
    output logic zero_flag_o,
    output logic nibble_borrow_flag_o,
    output logic carry_flag_o,
    output logic watchdog_expiry_flag_o,
    output logic powerdown_flag_o,
    output logic watchdog_clear_o,
    output logic halt_o
);
    import tie_pkg::*;

    tie_state_t state_q;
    logic [DATA_W-1:0] work_q;
    logic [DATA_W-1:0] tmode_q;
    logic [HIGH_W-1:0] high_q;
    logic [ROM_ADDR_W-1:0] rom_addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [REG_ADDR_W-1:0] waddr_q;
    logic we_q;
    logic z_q;
    logic nbr_q;
    logic c_q;
    logic to_q;
    logic pdn_q;
    logic wdog_clr_q;
    logic [DATA_W-1:0] alu_res;
    logic alu_z;
    logic alu_nbr;
    logic alu_c;
    logic [DATA_W-1:0] operand;
    logic go;
    logic to_reg;

    // ===========================================
    // Operand choice and arithmetic unit
    assign go = op_valid_i && (state_q == TIE_ST_IDLE);
    assign operand = (op_i == TIE_OP_IMM_MINUS_WORK
        || op_i == TIE_OP_IMM_EXCLUSIVE_OR) ? imm_i : reg_rdata_i;
    assign to_reg = (dest_i != DEST_WORK)
        && (op_i == TIE_OP_NIBBLE_EXCHANGE
        || op_i == TIE_OP_REG_EXCLUSIVE_OR);

    tie_flag_alu tie_flag_alu_i (
        .op_i(op_i),
        .work_i(work_q),
        .operand_i(operand),
        .result_o(alu_res),
        .zero_o(alu_z),
        .nibble_borrow_o(alu_nbr),
        .carry_o(alu_c)
    );

    // ===========================================
    // Sequencer: table read and halt
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= TIE_ST_IDLE;
            rom_addr_q <= '0;
        end
        else
        begin
            unique case (state_q)
                TIE_ST_IDLE:
                begin
                    if (go && op_i == TIE_OP_PROGRAM_WORD_READ)
                    begin
                        state_q <= TIE_ST_FETCH;
                        rom_addr_q <= {table_page_pointer_i,
                            work_q};
                    end
                    else if (go && op_i == TIE_OP_HALT)
                    begin
                        state_q <= TIE_ST_HALTED;
                    end
                end
                TIE_ST_FETCH:
                begin
                    state_q <= TIE_ST_IDLE;
                end
                TIE_ST_HALTED:
                begin
                    if (wake_i)
                    begin
                        state_q <= TIE_ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= TIE_ST_IDLE;
                end
            endcase
        end
    end

    // ===========================================
    // Work register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            work_q <= WORK_RST;
        end
        else if (state_q == TIE_ST_FETCH)
        begin
            work_q <= rom_data_i[DATA_W-1:0];
        end
        else if (go)
        begin
            unique case (op_i)
                TIE_OP_IMM_MINUS_WORK,
                TIE_OP_IMM_EXCLUSIVE_OR:
                    work_q <= alu_res;
                TIE_OP_NIBBLE_EXCHANGE,
                TIE_OP_REG_EXCLUSIVE_OR:
                    if (!to_reg)
                    begin
                        work_q <= alu_res;
                    end
                TIE_OP_TIMER_MODE_READ: work_q <= tmode_q;
                default: work_q <= work_q;
            endcase
        end
    end

    // ===========================================
    // Timer mode register and table high latch
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tmode_q <= TMODE_RST;
        end
        else if (go && op_i == TIE_OP_TIMER_MODE_LOAD)
        begin
            tmode_q <= work_q;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            high_q <= HIGH_RST;
        end
        else if (state_q == TIE_ST_FETCH)
        begin
            high_q <= rom_data_i[HIGH_LSB+HIGH_W-1:HIGH_LSB];
        end
    end

    // ===========================================
    // Register file write-back
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            we_q <= 1'b0;
            wdata_q <= ZERO_BYTE;
            waddr_q <= '0;
        end
        else
        begin
            we_q <= go && to_reg;
            if (go && to_reg)
            begin
                wdata_q <= alu_res;
                waddr_q <= reg_addr_i;
            end
        end
    end

    // ===========================================
    // Status flags
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            z_q <= 1'b0;
            nbr_q <= 1'b0;
            c_q <= 1'b0;
        end
        else if (go)
        begin
            if (op_i == TIE_OP_IMM_MINUS_WORK)
            begin
                z_q <= alu_z;
                nbr_q <= alu_nbr;
                c_q <= alu_c;
            end
            else if (op_i == TIE_OP_REG_EXCLUSIVE_OR
                || op_i == TIE_OP_IMM_EXCLUSIVE_OR)
            begin
                z_q <= alu_z;
            end
        end
    end

    // ===========================================
    // Halt entry: watchdog clear and power flags
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            to_q <= TO_RST;
            pdn_q <= PDN_RST;
            wdog_clr_q <= 1'b0;
        end
        else
        begin
            wdog_clr_q <= go && op_i == TIE_OP_HALT;
            if (go && op_i == TIE_OP_HALT)
            begin
                to_q <= TO_HALT;
                pdn_q <= PDN_HALT;
            end
        end
    end

    assign busy_o = (state_q != TIE_ST_IDLE);
    assign halt_o = (state_q == TIE_ST_HALTED);
    assign reg_addr_o = we_q ? waddr_q : reg_addr_i;
    assign reg_we_o = we_q;
    assign reg_wdata_o = wdata_q;
    assign rom_addr_o = rom_addr_q;
    assign work_register_o = work_q;
    assign timer_mode_reg_o = tmode_q;
    assign table_high_latch_o = high_q;
    assign zero_flag_o = z_q;
    assign nibble_borrow_flag_o = nbr_q;
    assign carry_flag_o = c_q;
    assign watchdog_expiry_flag_o = to_q;
    assign powerdown_flag_o = pdn_q;
    assign watchdog_clear_o = wdog_clr_q;
endmodule

// ==== test/tie_execute_asserts.sv ====
// Checker for the tail execute block
module tie_execute_chk
    import tie_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic op_valid_i,
    input wire logic dest_i,
    input wire logic busy_o,
    input wire tie_pkg::tie_op_t op_i,
    input wire logic [tie_pkg::DATA_W-1:0] imm_i,
    input wire logic [tie_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [tie_pkg::DATA_W-1:0] work_register_o,
    input wire logic [tie_pkg::DATA_W-1:0] timer_mode_reg_o,
    input wire logic [tie_pkg::PAGE_W-1:0] table_page_pointer_i,
    input wire logic [tie_pkg::ROM_DATA_W-1:0] rom_data_i,
    input wire logic [tie_pkg::ROM_ADDR_W-1:0] rom_addr_o,
    input wire logic [tie_pkg::HIGH_W-1:0] table_high_latch_o,
    input wire logic [tie_pkg::REG_ADDR_W-1:0] reg_addr_o,
    input wire logic reg_we_o,
    input wire logic zero_flag_o,
    input wire logic carry_flag_o,
    input wire logic halt_o,
    input wire logic watchdog_clear_o,
    input wire logic watchdog_expiry_flag_o,
    input wire logic powerdown_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic go;
    assign go = op_valid_i && !busy_o;
    // ========================================
    // Table read steps
    sequence s_tbl_addr;
        busy_o && rom_addr_o == $past({table_page_pointer_i, work_register_o});
    endsequence
    sequence s_tbl_data;
        work_register_o == $past(rom_data_i[7:0])
            && table_high_latch_o == $past(rom_data_i[13:8]);
    endsequence
    // ========================================
    // Properties
    a_halt_wdog_clear: assert property (
        go && op_i == TIE_OP_HALT |=> watchdog_clear_o ##1 !watchdog_clear_o)
        else $error("halt gave no clear pulse");
    a_halt_flag_set: assert property (
        go && op_i == TIE_OP_HALT |=> watchdog_expiry_flag_o
            && !powerdown_flag_o && halt_o && busy_o)
        else $error("halt flags wrong");
    a_sub_imm_result: assert property (
        go && op_i == TIE_OP_IMM_MINUS_WORK |=>
            work_register_o == $past(imm_i - work_register_o)
            && carry_flag_o == $past(imm_i >= work_register_o)
            && zero_flag_o == (work_register_o == 8'h00))
        else $error("subtract result wrong");
    a_swap_flags_kept: assert property (
        go && op_i == TIE_OP_NIBBLE_EXCHANGE |=>
            $stable(zero_flag_o) && $stable(carry_flag_o))
        else $error("swap changed flags");
    a_xor_dest_route: assert property (
        go && op_i == TIE_OP_REG_EXCLUSIVE_OR |=> reg_we_o == $past(dest_i))
        else $error("xor routed wrong");
    a_wb_addr_hold: assert property (
        go && dest_i && (op_i == TIE_OP_NIBBLE_EXCHANGE
            || op_i == TIE_OP_REG_EXCLUSIVE_OR) |=> reg_we_o
            && reg_addr_o == $past(reg_addr_i))
        else $error("write-back address wrong");
    a_tmode_load_copy: assert property (
        go && op_i == TIE_OP_TIMER_MODE_LOAD |=>
            timer_mode_reg_o == $past(work_register_o))
        else $error("timer mode load wrong");
    a_tmode_read_copy: assert property (
        go && op_i == TIE_OP_TIMER_MODE_READ |=>
            work_register_o == $past(timer_mode_reg_o))
        else $error("timer mode read wrong");
    a_table_two_step: assert property (
        go && op_i == TIE_OP_PROGRAM_WORD_READ |=> s_tbl_addr ##1 s_tbl_data)
        else $error("table read wrong");
endmodule

bind tie_execute tie_execute_chk tie_execute_chk_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .op_valid_i(op_valid_i), .dest_i(dest_i),
    .busy_o(busy_o), .op_i(op_i), .imm_i(imm_i),
    .reg_addr_i(reg_addr_i), .reg_addr_o(reg_addr_o),
    .work_register_o(work_register_o), .timer_mode_reg_o(timer_mode_reg_o),
    .table_page_pointer_i(table_page_pointer_i), .rom_data_i(rom_data_i),
    .rom_addr_o(rom_addr_o), .table_high_latch_o(table_high_latch_o),
    .reg_we_o(reg_we_o), .zero_flag_o(zero_flag_o), .halt_o(halt_o),
    .carry_flag_o(carry_flag_o), .watchdog_clear_o(watchdog_clear_o),
    .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
    .powerdown_flag_o(powerdown_flag_o));

// ==== test/tie_execute_tb_top.sv ====
// Self-checking bench for the tail execute block
module tie_execute_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tie_pkg::*;
    typedef struct {int due; logic [37:0] v; logic [37:0] m;} tie_note_t;
    tie_note_t notes[$];
    tie_note_t n;
    tie_op_t op = TIE_OP_NONE;
    logic clk = 0, arst_n_i = 0, vld = 0, dest = 0, wake = 0;
    logic [7:0] imm = 0, rd = 0, w = 0, tm = 0, w_o, tm_o, wd;
    logic [6:0] addr = 0;
    logic [2:0] pg = 0;
    logic [13:0] rom = 0;
    logic [5:0] hl = 0, hl_o;
    logic z = 0, nb = 0, c = 0, z_o, nb_o, c_o, we, to_o, pdn_o, clr_o, ht_o;
    logic [31:0] rnd = 32'h000110fe;
    int cnt = 0, num_errors = 0, tests_run = 0;

    always #50 clk = ~clk;

    tie_execute tie_execute_i (.clk_i(clk), .arst_n_i(arst_n_i),
        .op_valid_i(vld), .op_i(op), .imm_i(imm), .reg_addr_i(addr),
        .dest_i(dest), .reg_rdata_i(rd), .table_page_pointer_i(pg),
        .rom_data_i(rom), .wake_i(wake), .busy_o(), .reg_addr_o(),
        .reg_we_o(we), .reg_wdata_o(wd), .rom_addr_o(),
        .work_register_o(w_o), .timer_mode_reg_o(tm_o),
        .table_high_latch_o(hl_o), .zero_flag_o(z_o),
        .nibble_borrow_flag_o(nb_o), .carry_flag_o(c_o),
        .watchdog_expiry_flag_o(to_o), .powerdown_flag_o(pdn_o),
        .watchdog_clear_o(clr_o), .halt_o(ht_o));

    // ========================================
    // Helpers
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(logic [37:0] seen, logic [37:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic push(int d, logic wr, logic [7:0] wv, logic [3:0] hf,
                        logic [3:0] hm);
        notes.push_back('{cnt + d, {w, z, nb, c, wr, wv, tm, hl, hf},
                          {12'hfff, {8{wr}}, 14'h3fff, hm}});
    endtask

    // ========================================
    // Driver with reference model
    task automatic issue(tie_op_t o, logic d, logic eq);
        logic [7:0] i, r, v;
        @(posedge clk);
        rnd = nxt(rnd);
        i = eq ? w : rnd[7:0];
        r = rnd[15:8];
        v = 8'h00;
        vld <= 1;
        op <= o;
        dest <= d;
        imm <= i;
        rd <= r;
        addr <= rnd[22:16];
        pg <= rnd[25:23];
        case (o)
            TIE_OP_IMM_MINUS_WORK:
            begin
                c = i >= w;
                nb = i[3:0] >= w[3:0];
                w = i - w;
                z = w == 8'h00;
            end
            TIE_OP_NIBBLE_EXCHANGE: v = {r[3:0], r[7:4]};
            TIE_OP_TIMER_MODE_LOAD: tm = w;
            TIE_OP_TIMER_MODE_READ: w = tm;
            TIE_OP_REG_EXCLUSIVE_OR:
            begin
                v = w ^ r;
                z = v == 8'h00;
            end
            TIE_OP_IMM_EXCLUSIVE_OR:
            begin
                w = w ^ i;
                z = w == 8'h00;
            end
            default:
            begin
                w = rnd[23:16];
                hl = rnd[29:24];
            end
        endcase
        if (o == TIE_OP_NIBBLE_EXCHANGE || o == TIE_OP_REG_EXCLUSIVE_OR)
        begin
            if (!d)
                w = v;
        end
        if (o == TIE_OP_PROGRAM_WORD_READ)
        begin
            push(3, 0, 8'h00, 4'h0, 4'h3);
            @(posedge clk);
            rom <= rnd[29:16];
            op <= TIE_OP_IMM_EXCLUSIVE_OR;
        end
        else
            push(2, d && (o == TIE_OP_NIBBLE_EXCHANGE
                 || o == TIE_OP_REG_EXCLUSIVE_OR),
                 v, 4'h0, 4'h3);
    endtask

    // ========================================
    // Monitor
    initial forever @(negedge clk)
    begin
        cnt++;
        while (notes.size() > 0 && notes[0].due == cnt)
        begin
            n = notes.pop_front();
            check({w_o, z_o, nb_o, c_o, we, wd, tm_o, hl_o, to_o, pdn_o, ht_o,
                   clr_o} & n.m, n.v & n.m);
        end
    end

    initial
    begin
        #2000000;
        num_errors++;
        complete_run();
    end

    // ========================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n_i <= 1;
        push(1, 0, 8'h00, 4'hc, 4'hf);
        for (int k = 0; k < 200; k++)
            issue(tie_op_t'(2 + k % 7), k[3], k % 5 == 0);
        @(posedge clk);
        vld <= 1;
        op <= TIE_OP_HALT;
        push(2, 0, 8'h00, 4'hb, 4'hf);
        push(3, 0, 8'h00, 4'ha, 4'hf);
        @(posedge clk);
        op <= TIE_OP_IMM_EXCLUSIVE_OR;
        repeat (3) @(posedge clk);
        vld <= 0;
        wake <= 1;
        @(posedge clk);
        wake <= 0;
        for (int k = 0; k < 30; k++)
            issue(tie_op_t'(2 + k % 7), k[2], k % 4 == 0);
        @(posedge clk);
        vld <= 0;
        for (int t = 0; t < 10 && notes.size() > 0; t++)
            @(posedge clk);
        if (notes.size() > 0)
            num_errors++;
        complete_run();
    end
endmodule
